// [rtl/deip_pkg.sv]
// Shared constants and state types of the external DMA I/O port
`default_nettype none

package deip_pkg;

  // ==========================================================
  // Bus shape
  localparam int unsigned NCH       = 2;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned CNT_W_DEF = 16;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned STROBE_MIN_NS  = 120;
  localparam int unsigned STROBE_MIN_CYC = (STROBE_MIN_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // ==========================================================
  // State machines
  typedef enum logic [1:0] {
    DEIP_SQ_IDLE   = 2'b00,
    DEIP_SQ_SETUP  = 2'b01,
    DEIP_SQ_STROBE = 2'b10,
    DEIP_SQ_HOLD   = 2'b11
  } deip_seq_st_t;

  typedef enum logic [0:0] {
    DEIP_ST_IDLE = 1'b0,
    DEIP_ST_BUSY = 1'b1
  } deip_ctl_st_t;

endpackage

`default_nettype wire

// [rtl/deip_cyc_if.sv]
// Command link between the channel controller and the bus cycle sequencer
`default_nettype none

interface deip_cyc_if;
  import deip_pkg::*;
  logic              start;
  logic              write;
  logic              sel;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;

  modport ctrl (output start, output write, output sel, output addr, output wdata,
                input done, input rdata);
  modport seq  (input start, input write, input sel, input addr, input wdata,
                output done, output rdata);
endinterface

`default_nettype wire

// [rtl/deip_cycle.sv]
// Bus cycle sequencer: address setup, strobe, ready stretch, hold
`default_nettype none

module deip_cycle
  import deip_pkg::*;
#(
  parameter int unsigned STROBE_MIN = deip_pkg::STROBE_MIN_CYC
) (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Command link
  deip_cyc_if.seq                        cyc,
  // Raw pins in
  input  wire logic                      ready_i,
  input  wire logic [deip_pkg::DATA_W-1:0] data_i,
  // Pins out
  output logic [deip_pkg::NCH-1:0]       cs_o,
  output logic [deip_pkg::ADDR_W-1:0]    addr_o,
  output logic                           rd_o,
  output logic                           wr_o,
  output logic [deip_pkg::DATA_W-1:0]    data_o,
  output logic                           data_oe_o
);

  // ==========================================================
  // Pin synchronisers
  logic              rdy_meta_q, rdy_sync_q;
  logic [DATA_W-1:0] dd_meta_q, dd_sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdy_meta_q <= 1'b1;
      rdy_sync_q <= 1'b1;
      dd_meta_q  <= DATA_RST;
      dd_sync_q  <= DATA_RST;
    end else begin
      rdy_meta_q <= ready_i;
      rdy_sync_q <= rdy_meta_q;
      dd_meta_q  <= data_i;
      dd_sync_q  <= dd_meta_q;
    end
  end

  // ==========================================================
  // Cycle sequencer
  localparam logic [3:0] LAST_CNT = 4'(STROBE_MIN - 1);

  deip_seq_st_t      st_q, st_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [NCH-1:0]    cs_q, cs_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic              rd_q, rd_d, wr_q, wr_d, wsel_q, wsel_d, oe_q, oe_d;
  logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic              done_q, done_d;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    cs_d   = cs_q;
    addr_d = addr_q;
    rd_d   = rd_q;
    wr_d   = wr_q;
    wsel_d = wsel_q;
    oe_d   = oe_q;
    wdat_d = wdat_q;
    rdat_d = rdat_q;
    done_d = 1'b0;
    case (st_q)
      DEIP_SQ_IDLE: begin
        cs_d = '0;
        oe_d = 1'b0;
        if (cyc.start) begin
          addr_d = cyc.addr;
          cs_d   = cyc.sel ? 2'b10 : 2'b01;
          wsel_d = cyc.write;
          wdat_d = cyc.wdata;
          oe_d   = cyc.write;
          st_d   = DEIP_SQ_SETUP;
        end
      end
      DEIP_SQ_SETUP: begin
        rd_d  = ~wsel_q;
        wr_d  = wsel_q;
        cnt_d = 4'h0;
        st_d  = DEIP_SQ_STROBE;
      end
      DEIP_SQ_STROBE: begin
        // Ready is only trusted after the minimum width, since it arrives two clocks late
        if (cnt_q != LAST_CNT) begin
          cnt_d = cnt_q + 4'h1;
        end else if (rdy_sync_q) begin
          rd_d = 1'b0;
          wr_d = 1'b0;
          if (!wsel_q) begin
            rdat_d = dd_sync_q;
          end
          st_d = DEIP_SQ_HOLD;
        end
      end
      DEIP_SQ_HOLD: begin
        done_d = 1'b1;
        st_d   = DEIP_SQ_IDLE;
      end
      default: begin
        st_d = DEIP_SQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= DEIP_SQ_IDLE;
      cnt_q  <= 4'h0;
      cs_q   <= '0;
      addr_q <= ADDR_RST;
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      wsel_q <= 1'b0;
      oe_q   <= 1'b0;
      wdat_q <= DATA_RST;
      rdat_q <= DATA_RST;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      cs_q   <= cs_d;
      addr_q <= addr_d;
      rd_q   <= rd_d;
      wr_q   <= wr_d;
      wsel_q <= wsel_d;
      oe_q   <= oe_d;
      wdat_q <= wdat_d;
      rdat_q <= rdat_d;
      done_q <= done_d;
    end
  end

  assign cs_o      = cs_q;
  assign addr_o    = addr_q;
  assign rd_o      = rd_q;
  assign wr_o      = wr_q;
  assign data_o    = wdat_q;
  assign data_oe_o = oe_q;
  assign cyc.done  = done_q;
  assign cyc.rdata = rdat_q;

endmodule

`default_nettype wire

// [rtl/deip_port.sv]
// External I/O side of the two-channel DMA unit
`default_nettype none

module deip_port
  import deip_pkg::*;
#(
  parameter int unsigned CNT_W      = deip_pkg::CNT_W_DEF,
  parameter int unsigned STROBE_MIN = deip_pkg::STROBE_MIN_CYC
) (
  // Clock and reset
  input  wire logic                                          clk_i,
  input  wire logic                                          rst_i,
  // Channel setup from the controller core
  input  wire logic [deip_pkg::NCH-1:0]                      chan_start_i,
  input  wire logic [deip_pkg::NCH-1:0]                      chan_write_i,
  input  wire logic [deip_pkg::NCH-1:0]                      chan_cs_i,
  input  wire logic [deip_pkg::NCH-1:0][deip_pkg::ADDR_W-1:0] chan_addr_i,
  input  wire logic [deip_pkg::NCH-1:0][CNT_W-1:0]           chan_count_i,
  output logic [deip_pkg::NCH-1:0]                           chan_busy_o,
  // Memory-side byte streams
  input  wire logic [deip_pkg::NCH-1:0][deip_pkg::DATA_W-1:0] tx_byte_i,
  input  wire logic [deip_pkg::NCH-1:0]                      tx_valid_i,
  output logic [deip_pkg::NCH-1:0]                           tx_ready_o,
  output logic [deip_pkg::DATA_W-1:0]                        rx_byte_o,
  output logic                                               rx_valid_o,
  output logic                                               rx_chan_o,
  // Programming access to the I/O devices
  input  wire logic                                          prog_req_i,
  input  wire logic                                          prog_write_i,
  input  wire logic                                          prog_sel_i,
  input  wire logic [deip_pkg::ADDR_W-1:0]                   prog_addr_i,
  input  wire logic [deip_pkg::DATA_W-1:0]                   prog_wdata_i,
  output logic                                               prog_done_o,
  output logic [deip_pkg::DATA_W-1:0]                        prog_rdata_o,
  // Handshake pins
  input  wire logic                                          transfer_request_ch0_i,
  input  wire logic                                          transfer_request_ch1_i,
  output logic                                               transfer_grant_ch0_o,
  output logic                                               transfer_grant_ch1_o,
  output logic                                               terminal_count_ch0_o,
  output logic                                               terminal_count_ch1_o,
  input  wire logic                                          peripheral_ready_extend_i,
  // Bus pins
  output logic                                               chip_select_first_o,
  output logic                                               chip_select_second_o,
  output logic [0:deip_pkg::ADDR_W-1]                        peripheral_address_lines_o,
  output logic                                               io_read_strobe_o,
  output logic                                               io_write_strobe_o,
  input  wire logic [0:deip_pkg::DATA_W-1]                   peripheral_byte_lines_i,
  output logic [0:deip_pkg::DATA_W-1]                        peripheral_byte_lines_o,
  output logic                                               peripheral_byte_lines_oe_o
);

  // ==========================================================
  // Request synchronisers and eligibility
  logic [NCH-1:0] req_raw;
  logic [NCH-1:0] req_meta_q, req_sync_q;
  logic [NCH-1:0] elig;
  logic [NCH-1:0] act_q, act_d, wr_q, wr_d, csel_q, csel_d;
  logic [NCH-1:0][ADDR_W-1:0] addr_q, addr_d;
  logic [NCH-1:0][CNT_W-1:0]  cnt_q, cnt_d;

  assign req_raw = {transfer_request_ch1_i, transfer_request_ch0_i};

  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        req_meta_q[ch] <= 1'b0;
        req_sync_q[ch] <= 1'b0;
      end else begin
        req_meta_q[ch] <= req_raw[ch];
        req_sync_q[ch] <= req_meta_q[ch];
      end
    end
    // A write channel waits for its memory byte before it may bid
    assign elig[ch] = act_q[ch] & req_sync_q[ch] & (~wr_q[ch] | tx_valid_i[ch]);
  end

  // ==========================================================
  // Cycle sequencer
  deip_cyc_if cyc ();

  logic [NCH-1:0]    cs_pins;
  logic [ADDR_W-1:0] addr_pins;
  logic [DATA_W-1:0] dd_out;

  deip_cycle #(
    .STROBE_MIN (STROBE_MIN)
  ) u_cycle (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .cyc       (cyc.seq),
    .ready_i   (peripheral_ready_extend_i),
    .data_i    (peripheral_byte_lines_i),
    .cs_o      (cs_pins),
    .addr_o    (addr_pins),
    .rd_o      (io_read_strobe_o),
    .wr_o      (io_write_strobe_o),
    .data_o    (dd_out),
    .data_oe_o (peripheral_byte_lines_oe_o)
  );

  // ==========================================================
  // Channel controller
  deip_ctl_st_t      st_q, st_d;
  logic              own_q, own_d, prog_q, prog_d;
  logic              start_q, start_d, iwr_q, iwr_d, isel_q, isel_d;
  logic [ADDR_W-1:0] iaddr_q, iaddr_d;
  logic [DATA_W-1:0] idat_q, idat_d;
  logic [NCH-1:0]    grant_q, grant_d, tc_q, tc_d, txr_q, txr_d;
  logic              rxv_q, rxv_d, rxch_q, rxch_d, pdone_q, pdone_d;

  always_comb begin
    st_d    = st_q;
    own_d   = own_q;
    prog_d  = prog_q;
    start_d = 1'b0;
    iwr_d   = iwr_q;
    isel_d  = isel_q;
    iaddr_d = iaddr_q;
    idat_d  = idat_q;
    grant_d = grant_q;
    tc_d    = '0;
    txr_d   = '0;
    rxv_d   = 1'b0;
    rxch_d  = rxch_q;
    pdone_d = 1'b0;
    act_d   = act_q;
    wr_d    = wr_q;
    csel_d  = csel_q;
    addr_d  = addr_q;
    cnt_d   = cnt_q;
    case (st_q)
      DEIP_ST_IDLE: begin
        // Fixed priority: channel 0, channel 1, then programming
        if (elig[0] || elig[1]) begin
          own_d          = elig[0] ? 1'b0 : 1'b1;
          prog_d         = 1'b0;
          start_d        = 1'b1;
          iwr_d          = wr_q[own_d];
          isel_d         = csel_q[own_d];
          iaddr_d        = addr_q[own_d];
          idat_d         = tx_byte_i[own_d];
          txr_d[own_d]   = wr_q[own_d];
          grant_d[own_d] = 1'b1;
          st_d           = DEIP_ST_BUSY;
        end else if (prog_req_i) begin
          prog_d  = 1'b1;
          start_d = 1'b1;
          iwr_d   = prog_write_i;
          isel_d  = prog_sel_i;
          iaddr_d = prog_addr_i;
          idat_d  = prog_wdata_i;
          st_d    = DEIP_ST_BUSY;
        end
      end
      DEIP_ST_BUSY: begin
        if (cyc.done) begin
          grant_d = '0;
          st_d    = DEIP_ST_IDLE;
          if (prog_q) begin
            pdone_d = 1'b1;
          end else begin
            rxv_d        = ~wr_q[own_q];
            rxch_d       = own_q;
            cnt_d[own_q] = cnt_q[own_q] - CNT_W'(1);
            if (cnt_q[own_q] == CNT_W'(1)) begin
              tc_d[own_q]  = 1'b1;
              act_d[own_q] = 1'b0;
            end
          end
        end
      end
      default: begin
        st_d = DEIP_ST_IDLE;
      end
    endcase
    // A fresh setup overrides whatever the finished cycle did to that channel
    for (int ch = 0; ch < NCH; ch++) begin
      if (chan_start_i[ch]) begin
        act_d[ch]  = |chan_count_i[ch];
        cnt_d[ch]  = chan_count_i[ch];
        wr_d[ch]   = chan_write_i[ch];
        csel_d[ch] = chan_cs_i[ch];
        addr_d[ch] = chan_addr_i[ch];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= DEIP_ST_IDLE;
      own_q   <= 1'b0;
      prog_q  <= 1'b0;
      start_q <= 1'b0;
      iwr_q   <= 1'b0;
      isel_q  <= 1'b0;
      iaddr_q <= ADDR_RST;
      idat_q  <= DATA_RST;
      grant_q <= '0;
      tc_q    <= '0;
      txr_q   <= '0;
      rxv_q   <= 1'b0;
      rxch_q  <= 1'b0;
      pdone_q <= 1'b0;
      act_q   <= '0;
      wr_q    <= '0;
      csel_q  <= '0;
      addr_q  <= '0;
      cnt_q   <= '0;
    end else begin
      st_q    <= st_d;
      own_q   <= own_d;
      prog_q  <= prog_d;
      start_q <= start_d;
      iwr_q   <= iwr_d;
      isel_q  <= isel_d;
      iaddr_q <= iaddr_d;
      idat_q  <= idat_d;
      grant_q <= grant_d;
      tc_q    <= tc_d;
      txr_q   <= txr_d;
      rxv_q   <= rxv_d;
      rxch_q  <= rxch_d;
      pdone_q <= pdone_d;
      act_q   <= act_d;
      wr_q    <= wr_d;
      csel_q  <= csel_d;
      addr_q  <= addr_d;
      cnt_q   <= cnt_d;
    end
  end

  assign cyc.start = start_q;
  assign cyc.write = iwr_q;
  assign cyc.sel   = isel_q;
  assign cyc.addr  = iaddr_q;
  assign cyc.wdata = idat_q;

  // ==========================================================
  // Outputs
  assign chan_busy_o          = act_q;
  assign tx_ready_o           = txr_q;
  assign rx_byte_o            = cyc.rdata;
  assign rx_valid_o           = rxv_q;
  assign rx_chan_o            = rxch_q;
  assign prog_done_o          = pdone_q;
  assign prog_rdata_o         = cyc.rdata;
  assign transfer_grant_ch0_o = grant_q[0];
  assign transfer_grant_ch1_o = grant_q[1];
  assign terminal_count_ch0_o = tc_q[0];
  assign terminal_count_ch1_o = tc_q[1];
  assign chip_select_first_o  = cs_pins[0];
  assign chip_select_second_o = cs_pins[1];
  // Descending to ascending ranges: internal msb lands on line 0
  assign peripheral_address_lines_o = addr_pins;
  assign peripheral_byte_lines_o    = dd_out;

endmodule

`default_nettype wire

// [tb/deip_port_props.sv]
// Concurrent checks on the pins of the external DMA I/O port
`default_nettype none

module deip_port_props (
  // Clock and reset
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  // Watched pins
  input wire logic                        transfer_grant_ch0_o,
  input wire logic                        transfer_grant_ch1_o,
  input wire logic                        terminal_count_ch0_o,
  input wire logic                        terminal_count_ch1_o,
  input wire logic                        peripheral_ready_extend_i,
  input wire logic                        chip_select_first_o,
  input wire logic                        chip_select_second_o,
  input wire logic [0:deip_pkg::ADDR_W-1] peripheral_address_lines_o,
  input wire logic                        io_read_strobe_o,
  input wire logic                        io_write_strobe_o,
  input wire logic                        peripheral_byte_lines_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Properties
  property p_one_grant; !(transfer_grant_ch0_o && transfer_grant_ch1_o); endproperty
  property p_one_cs; !(chip_select_first_o && chip_select_second_o); endproperty
  property p_strobe_cs;
    (io_read_strobe_o || io_write_strobe_o) |-> (chip_select_first_o || chip_select_second_o);
  endproperty
  property p_strobe_min; $rose(io_read_strobe_o || io_write_strobe_o) |-> (io_read_strobe_o || io_write_strobe_o) [*3]; endproperty
  // Three low samples of ready mean the synchronised copy is still low
  property p_stretch;
    (io_read_strobe_o || io_write_strobe_o) && !peripheral_ready_extend_i
      && !$past(peripheral_ready_extend_i) && !$past(peripheral_ready_extend_i, 2)
      |=> (io_read_strobe_o || io_write_strobe_o);
  endproperty
  property p_rd_no_drive; peripheral_byte_lines_oe_o |-> !io_read_strobe_o; endproperty
  property p_wr_drive; io_write_strobe_o |-> peripheral_byte_lines_oe_o && !io_read_strobe_o; endproperty
  property p_tc0; terminal_count_ch0_o |-> $past(transfer_grant_ch0_o) ##1 !terminal_count_ch0_o; endproperty
  property p_tc1; terminal_count_ch1_o |-> $past(transfer_grant_ch1_o) ##1 !terminal_count_ch1_o; endproperty
  property p_addr_hold;
    io_read_strobe_o && $past(io_read_strobe_o) |-> $stable(peripheral_address_lines_o);
  endproperty
  // ==========================================================
  // Assertions
  a_one_grant: assert property (p_one_grant) else $error("both grants high");
  a_one_cs: assert property (p_one_cs) else $error("both chip selects high");
  a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");
  a_strobe_min: assert property (p_strobe_min) else $error("strobe too short");
  a_stretch: assert property (p_stretch) else $error("strobe ended with ready low");
  a_rd_no_drive: assert property (p_rd_no_drive) else $error("driving during read");
  a_wr_drive: assert property (p_wr_drive) else $error("write without drive");
  a_tc0: assert property (p_tc0) else $error("tc0 pulse wrong");
  a_tc1: assert property (p_tc1) else $error("tc1 pulse wrong");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in strobe");
  c_tc0: cover property (terminal_count_ch0_o);
  c_write: cover property (io_write_strobe_o);
  c_stretch: cover property (io_read_strobe_o && !peripheral_ready_extend_i);
endmodule

bind deip_port deip_port_props u_deip_port_props (.*);

`default_nettype wire

// [tb/deip_periph.sv]
// Behavioural 8-bit I/O peripheral on the far side of the port
`default_nettype none

module deip_periph (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Bench controls
  input wire logic [1:0] req_en_i,
  input wire logic [3:0] stretch_i,
  input wire logic [7:0] rdat_i,
  // Pins from the port
  input wire logic [1:0] grant_i,
  input wire logic       sel_i,
  input wire logic       rd_i,
  input wire logic       wr_i,
  input wire logic [0:7] bus_i,
  // Pins to the port
  output logic [1:0]     req_o,
  output logic           ready_o,
  output logic [0:7]     drv_o,
  output logic [7:0]     wbyte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic       strb_q;
  logic [7:0] last_q;
  // With a nonzero stretch_i, ready drops in the strobe's first cycle, so the port's two-flop lag still catches it
  assign ready_o = (cnt_q == 4'h0) &&
                   !((rd_i | wr_i) && sel_i && !strb_q && (stretch_i != 4'h0));
  // Released lines show the inverse of the last value, never a stale copy
  assign drv_o = (rd_i && sel_i) ? rdat_i : ~last_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      strb_q <= 1'b0;
      req_o <= 2'b00;
      last_q <= 8'h00;
    end else begin
      strb_q <= rd_i | wr_i;
      if ((rd_i | wr_i) && !strb_q) cnt_q <= stretch_i;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      req_o <= req_en_i & ~grant_i;
      last_q <= bus_i;
      if (wr_i) wbyte_o <= bus_i;
    end
  end
endmodule

`default_nettype wire

// [tb/dma_external_io_port_test.sv]
// Scenario testbench for the external DMA I/O port
`default_nettype none

module dma_external_io_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import deip_pkg::*;
  logic clk_i, rst_i, ready, rd, wr, oe, prog_req, prog_write, prog_sel, prog_done;
  logic [1:0] start, write, cs, busy, tx_valid, req_en, req, grant, tc, txr;
  logic [1:0][11:0] addr;
  logic [1:0][15:0] count;
  logic [1:0][7:0] tx_byte;
  logic [11:0] prog_addr;
  logic [7:0] prog_wdata, prog_rdata, rx_byte, rx_last, rdat, wbyte;
  logic rx_valid, cs1, cs2, rx_ch, rx_ch_last;
  logic [0:11] a_lines, addr_seen;
  logic [0:7] bus, dut_o, mdl_o;
  logic [3:0] stretch;
  logic [1:0] cs_seen;
  int errors, n_checks, w, w_last, rx_n, gn, txr_n, tc_n[2];

  assign bus = oe ? dut_o : mdl_o;
  deip_port #(.CNT_W(16)) u_deip_port (.clk_i(clk_i), .rst_i(rst_i),
    .chan_start_i(start), .chan_write_i(write), .chan_cs_i(cs), .chan_addr_i(addr),
    .chan_count_i(count), .chan_busy_o(busy), .tx_byte_i(tx_byte), .tx_valid_i(tx_valid),
    .tx_ready_o(txr), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .rx_chan_o(rx_ch),
    .prog_req_i(prog_req), .prog_write_i(prog_write), .prog_sel_i(prog_sel),
    .prog_addr_i(prog_addr), .prog_wdata_i(prog_wdata), .prog_done_o(prog_done),
    .prog_rdata_o(prog_rdata), .transfer_request_ch0_i(req[0]),
    .transfer_request_ch1_i(req[1]), .transfer_grant_ch0_o(grant[0]),
    .transfer_grant_ch1_o(grant[1]), .terminal_count_ch0_o(tc[0]),
    .terminal_count_ch1_o(tc[1]), .peripheral_ready_extend_i(ready),
    .chip_select_first_o(cs1), .chip_select_second_o(cs2),
    .peripheral_address_lines_o(a_lines), .io_read_strobe_o(rd), .io_write_strobe_o(wr),
    .peripheral_byte_lines_i(bus), .peripheral_byte_lines_o(dut_o),
    .peripheral_byte_lines_oe_o(oe));
  deip_periph u_deip_periph (.clk_i(clk_i), .rst_i(rst_i), .req_en_i(req_en),
    .stretch_i(stretch), .rdat_i(rdat), .grant_i(grant), .sel_i(cs1 | cs2), .rd_i(rd),
    .wr_i(wr), .bus_i(bus), .req_o(req), .ready_o(ready), .drv_o(mdl_o), .wbyte_o(wbyte));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ==========================================================
  // Pin monitor: strobe width, select and address seen in the strobe
  always @(posedge clk_i) begin
    if (!rst_i) begin
      if (tc[0]) tc_n[0]++;
      if (tc[1]) tc_n[1]++;
      if (txr[1]) txr_n++;
      if (rx_valid) begin
        rx_n++;
        rx_last = rx_byte;
        rx_ch_last = rx_ch;
      end
      if (grant != 2'b00) gn++;
      if (rd | wr) begin
        w++;
        cs_seen = {cs2, cs1};
        addr_seen = a_lines;
      end else if (w != 0) begin
        w_last = w;
        w = 0;
      end
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic arm(input int ch, input logic wr_d, input logic cs_d, input logic [11:0] a,
                     input logic [15:0] n);
    @(posedge clk_i) #2;
    write[ch] = wr_d;
    cs[ch] = cs_d;
    addr[ch] = a;
    count[ch] = n;
    start[ch] = 1'b1;
    @(posedge clk_i) #2;
    start[ch] = 1'b0;
  endtask

  task automatic run(input int ch);
    int i;
    i = 0;
    req_en[ch] = 1'b1;
    while (busy[ch] !== 1'b0 && i < 400) begin
      @(posedge clk_i) #2;
      i++;
    end
    req_en[ch] = 1'b0;
    chk("busy wait", 16'h0, (i == 400));
    repeat (4) @(posedge clk_i) #2;
  endtask

  task automatic t_read;
    int t0, r0, g0;
    t0 = tc_n[0];
    r0 = rx_n;
    g0 = gn;
    stretch = 4'h0;
    rdat = 8'hc3;
    arm(0, 1'b0, 1'b0, 12'ha53, 16'h2);
    run(0);
    chk("rx count", 16'h2, 16'(rx_n - r0));
    chk("grant seen", 16'h1, (gn != g0));
    chk("rx channel", 16'h0, {15'h0, rx_ch_last});
    chk("rx byte", 16'hc3, {8'h0, rx_last});
    chk("tc0 pulses", 16'h1, 16'(tc_n[0] - t0));
    chk("select", 16'h1, {14'h0, cs_seen});
    chk("address", 16'ha53, {4'h0, addr_seen});
    chk("msb line", 16'h1, {15'h0, addr_seen[0]});
    chk("strobe width", 16'h3, 16'(w_last));
    $display("t_read done");
  endtask

  task automatic t_write;
    int t1, x1;
    t1 = tc_n[1];
    x1 = txr_n;
    stretch = 4'h6;
    tx_byte[1] = 8'h96;
    tx_valid[1] = 1'b1;
    arm(1, 1'b1, 1'b1, 12'h80e, 16'h1);
    run(1);
    tx_valid[1] = 1'b0;
    chk("write byte", 16'h96, {8'h0, wbyte});
    chk("select", 16'h2, {14'h0, cs_seen});
    chk("tc1 pulses", 16'h1, 16'(tc_n[1] - t1));
    chk("tx taken", 16'h1, 16'(txr_n - x1));
    chk("stretched", 16'h1, (w_last >= 7));
    $display("t_write done");
  endtask

  task automatic t_prog(input logic wr_d, input logic sel, input logic [7:0] d);
    int i;
    stretch = 4'h2;
    rdat = d;
    @(posedge clk_i) #2;
    {prog_req, prog_write, prog_sel, prog_addr, prog_wdata} = {1'b1, wr_d, sel, 12'h0f1, d};
    i = 0;
    while (prog_done !== 1'b1 && i < 200) begin
      @(posedge clk_i) #2;
      i++;
    end
    prog_req = 1'b0;
    chk("prog done", 16'h0, (i == 200));
    if (wr_d) chk("prog write", {8'h0, d}, {8'h0, wbyte});
    else chk("prog read", {8'h0, d}, {8'h0, prog_rdata});
    chk("prog select", {14'h0, sel, ~sel}, {14'h0, cs_seen});
    repeat (3) @(posedge clk_i) #2;
    $display("t_prog done");
  endtask

  task automatic t_zero;
    int g0;
    arm(0, 1'b0, 1'b0, 12'h001, 16'h0);
    g0 = gn;
    req_en[0] = 1'b1;
    repeat (40) @(posedge clk_i) #2;
    req_en[0] = 1'b0;
    chk("zero busy", 16'h0, {15'h0, busy[0]});
    chk("zero grants", 16'h0, 16'(gn - g0));
    $display("t_zero done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200000;
    errors++;
    results();
  end

  initial begin
    {start, write, cs, tx_valid, req_en, prog_req, prog_write, prog_sel} = '0;
    addr = '0;
    count = '0;
    tx_byte = '0;
    {prog_addr, prog_wdata, rdat, stretch} = '0;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    #2 rst_i = 1'b0;
    repeat (2) @(posedge clk_i) #2;
    t_read();
    t_write();
    t_prog(1'b0, 1'b1, 8'h3c);
    t_prog(1'b1, 1'b0, 8'h5e);
    t_zero();
    results();
  end
endmodule

`default_nettype wire
